// [hdl/tpss_top.sv]
/*
 Task period sync scheduler: aligns the position task period of one module to a
 trigger shared by the option modules of one drive, with an AHB-Lite register file.
 Assumes TRIG_IN, LINK_INT_IN and TASK_DONE are synchronous to REF_CLK.
*/
// Overview of operation
// [RULE1]: One module is trigger source, others sinks; trigger travels on internal pin.
// [RULE2]: A sink uses the received trigger to shift its task scheduling phase.
// [RULE3]: A source emits one trigger at each own period start, up to 8 ms.
// [RULE4]: Period code 1=250us, 2=500us, 3=1ms, 4=2ms.
// [RULE5]: A sink synchronises when its period is equal to or shorter than trigger period.
// [RULE6]: A sink slower than the trigger does not synchronise and reports status 2.
// [RULE7]: Role 1 is source, 2 is sink; status shows whether the role is achieved.
// [RULE8]: Status 6 means sink sync achieved, 5 means source operation achieved.
// [RULE9]: A source timed by the link interrupt signal reports status 13.
// [RULE10]: The status register is read only.
// [RULE11]: A cross drive link slave forces its role to source.
// [RULE12]: Cross drive alignment needs one link master and one link slave elsewhere.
// [RULE13]: Cross drive mode 1 is off, 25 is link master, 26 is link slave.
// [RULE14]: Each period runs first task, advanced motion task, second task in order.
// [RULE15]: Only the start of the whole task sequence is phase aligned.
// [RULE16]: A faster sink restarts its period counter at each trigger.
`timescale 1ns/100ps
`include "tpss_defs.svh"

module tpss_top
	import tpss_pkg::*;
#(
	parameter int TICK_CYCLES = `TPSS_TICK_CYC
)
(
	// Clock and reset
	input wire logic REF_CLK,
	input wire logic RST_N,
	// AHB-Lite slave
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire logic [31:0] HWDATA,
	input wire logic HREADY,
	output logic [31:0] HRDATA,
	output logic HREADYOUT,
	output logic HRESP,
	// Trigger between modules
	input wire logic TRIG_IN,
	output logic TRIG_OUT,
	input wire logic LINK_INT_IN,
	// Task slots
	input wire logic [2:0] TASK_DONE,
	output logic [2:0] TASK_START,
	// Interrupt
	output logic IRQ
);

	// ============================================================
	// Bus address phase
	tpss_acc_s acc;
	wire accept = HSEL && HREADY && HTRANS[1];
	wire rd_now = acc.valid && !acc.write;
	wire wr_now = acc.valid && acc.write;
	wire wr_ctrl = wr_now && (acc.addr == `TPSS_OFS_CTRL);
	wire wr_mask = wr_now && (acc.addr == `TPSS_OFS_INT_MASK);
	wire rd_ist = rd_now && (acc.addr == `TPSS_OFS_INT_STAT);

	always_ff @(posedge REF_CLK or negedge RST_N)
	begin
		if (!RST_N)
			acc <= '0;
		else
			acc <= '{valid: accept, write: HWRITE, addr: HADDR[7:0]};
	end

	// Reads take one wait state, writes none
	always_ff @(posedge REF_CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			HREADYOUT <= 1'b1;
			HRESP <= 1'b0;
		end
		else
		begin
			HREADYOUT <= !(accept && !HWRITE);
			HRESP <= 1'b0;
		end
	end

	// ============================================================
	// Configuration
	tpss_cfg_s cfg;
	tpss_cfg_s next_cfg;
	wire [4:0] wr_xmode = wr_ctrl ? HWDATA[`TPSS_XM_MSB:`TPSS_XM_LSB] : cfg.xmode;
	wire [1:0] wr_role = wr_ctrl ? HWDATA[`TPSS_ROLE_MSB:`TPSS_ROLE_LSB] : cfg.role;
	wire link_slave_mode = (wr_xmode == `TPSS_XM_SLAVE); // [RULE13]

	assign next_cfg.xmode = wr_xmode;
	assign next_cfg.role = link_slave_mode ? `TPSS_ROLE_SRC : wr_role; // [RULE11]
	assign next_cfg.period = wr_ctrl ? HWDATA[`TPSS_PER_MSB:`TPSS_PER_LSB] : cfg.period;

	logic [`TPSS_EV_W-1:0] mask;

	always_ff @(posedge REF_CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			cfg <= '{xmode: `TPSS_XM_RST, role: `TPSS_ROLE_RST, period: `TPSS_PER_RST};
			mask <= '0;
		end
		else
		begin
			cfg <= next_cfg;
			if (wr_mask)
				mask <= HWDATA[`TPSS_EV_W-1:0];
		end
	end

	// ============================================================
	// Role decode
	wire role_src = (cfg.role == `TPSS_ROLE_SRC); // [RULE7]
	wire role_sink = (cfg.role == `TPSS_ROLE_SINK); // [RULE7]
	wire link_src = role_src && (cfg.xmode == `TPSS_XM_SLAVE);
	wire [5:0] own_ticks = tpss_period_ticks(cfg.period); // [RULE4]
	wire per_ok = (own_ticks != 6'h00);
	wire [`TPSS_SINCE_W-1:0] own_cyc = `TPSS_SINCE_W'(own_ticks) * `TPSS_SINCE_W'(TICK_CYCLES);

	// ============================================================
	// Trigger and link edges
	logic trig_q;
	logic link_q;
	wire trig_rise = TRIG_IN && !trig_q;
	wire link_rise = LINK_INT_IN && !link_q;

	always_ff @(posedge REF_CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			trig_q <= 1'b0;
			link_q <= 1'b0;
		end
		else
		begin
			trig_q <= TRIG_IN;
			link_q <= LINK_INT_IN;
		end
	end

	// ============================================================
	// Trigger period measurement
	logic [`TPSS_SINCE_W-1:0] since;
	logic [`TPSS_SINCE_W-1:0] trig_cyc;
	logic [1:0] trig_cnt;
	logic link_seen;
	wire trig_known = (trig_cnt == `TPSS_TRIG_KNOWN);
	wire too_slow = own_cyc > trig_cyc; // [RULE5] [RULE6]
	wire since_sat = (since == `TPSS_SINCE_MAX);
	wire [`TPSS_SINCE_W-1:0] next_since = since_sat ? since : since + `TPSS_SINCE_W'(1);
	wire [1:0] next_trig_cnt = trig_known ? trig_cnt : trig_cnt + 2'h1;

	always_ff @(posedge REF_CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			since <= '0;
			trig_cyc <= '0;
			trig_cnt <= 2'h0;
		end
		else if (!role_sink)
		begin
			since <= '0;
			trig_cnt <= 2'h0;
		end
		else if (trig_rise)
		begin
			since <= `TPSS_SINCE_W'(1);
			trig_cyc <= since;
			trig_cnt <= next_trig_cnt;
		end
		else
			since <= next_since;
	end

	always_ff @(posedge REF_CLK or negedge RST_N)
	begin
		if (!RST_N)
			link_seen <= 1'b0;
		else
			link_seen <= link_src && (link_seen || link_rise);
	end

	// ============================================================
	// Period timer and task slots
	wire sink_sync = role_sink && trig_known && !too_slow; // [RULE5]
	wire restart = (sink_sync && trig_rise) || (link_src && link_rise); // [RULE2] [RULE16]
	logic period_start;

	tpss_period_timer #(.TICK_CYCLES(TICK_CYCLES)) u_timer
	(
		.clk(REF_CLK),
		.rst_n(RST_N),
		.run(per_ok),
		.restart(restart),
		.period_ticks(own_ticks),
		.period_start(period_start)
	);

	tpss_task_seq u_seq
	(
		.clk(REF_CLK),
		.rst_n(RST_N),
		.period_start(period_start),
		.task_done(TASK_DONE),
		.task_start(TASK_START)
	);

	// Only a source drives the shared trigger
	always_ff @(posedge REF_CLK or negedge RST_N)
	begin
		if (!RST_N)
			TRIG_OUT <= 1'b0;
		else
			TRIG_OUT <= role_src && period_start; // [RULE1] [RULE3]
	end

	// ============================================================
	// Sync status, never written by software
	logic [7:0] status;
	wire [7:0] src_status = link_src ? (link_seen ? `TPSS_ST_LINK : `TPSS_ST_NONE) :
		`TPSS_ST_SRC; // [RULE8] [RULE9]
	wire [7:0] sink_status = !trig_known ? `TPSS_ST_NONE :
		(too_slow ? `TPSS_ST_SLOW : `TPSS_ST_SINK); // [RULE6] [RULE8]
	wire [7:0] next_status = !per_ok ? `TPSS_ST_NONE : role_src ? src_status :
		role_sink ? sink_status : `TPSS_ST_NONE; // [RULE7]
	wire next_ach = (next_status == `TPSS_ST_SRC) || (next_status == `TPSS_ST_SINK) ||
		(next_status == `TPSS_ST_LINK);
	wire cur_ach = (status == `TPSS_ST_SRC) || (status == `TPSS_ST_SINK) ||
		(status == `TPSS_ST_LINK);

	always_ff @(posedge REF_CLK or negedge RST_N)
	begin
		if (!RST_N)
			status <= `TPSS_ST_NONE;
		else
			status <= next_status; // [RULE10]
	end

	// ============================================================
	// Interrupt status, cleared by read, set wins
	logic [`TPSS_EV_W-1:0] int_stat;
	logic [`TPSS_EV_W-1:0] events;
	assign events[`TPSS_EV_TRIG_OUT] = role_src && period_start;
	assign events[`TPSS_EV_TRIG_IN] = role_sink && trig_rise;
	assign events[`TPSS_EV_ACHIEVED] = next_ach && !cur_ach;
	assign events[`TPSS_EV_SLOW] = (next_status == `TPSS_ST_SLOW) && (status != `TPSS_ST_SLOW);
	wire [`TPSS_EV_W-1:0] kept = rd_ist ? '0 : int_stat;
	wire [`TPSS_EV_W-1:0] next_int = kept | events;

	always_ff @(posedge REF_CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			int_stat <= '0;
			IRQ <= 1'b0;
		end
		else
		begin
			int_stat <= next_int;
			IRQ <= |(int_stat & mask);
		end
	end

	// ============================================================
	// Read data
	wire [31:0] ctrl_word = {11'h000, cfg.xmode, 6'h00, cfg.role, 5'h00, cfg.period};
	wire [31:0] rd_mux = (acc.addr == `TPSS_OFS_CTRL) ? ctrl_word :
		(acc.addr == `TPSS_OFS_STATUS) ? {24'h000000, status} :
		(acc.addr == `TPSS_OFS_INT_STAT) ? {28'h0000000, int_stat} :
		(acc.addr == `TPSS_OFS_INT_MASK) ? {28'h0000000, mask} : 32'h00000000;

	always_ff @(posedge REF_CLK or negedge RST_N)
	begin
		if (!RST_N)
			HRDATA <= 32'h00000000;
		else if (rd_now)
			HRDATA <= rd_mux;
	end

	// ============================================================
	// Checks
	sequence s_sink_trig;
		per_ok && sink_sync && trig_rise;
	endsequence

	sequence s_aligned_start;
		period_start ##1 TASK_START == 3'h1;
	endsequence

	a_trig_source_only: assert property (@(posedge REF_CLK) disable iff (!RST_N) // [RULE1]
		TRIG_OUT |-> $past(role_src))
		else $error("Trigger driven by a module not in source role");

	a_sink_realign: assert property (@(posedge REF_CLK) disable iff (!RST_N) // [RULE16]
		s_sink_trig |=> s_aligned_start)
		else $error("Sink did not restart its period at the trigger");

	a_source_emits: assert property (@(posedge REF_CLK) disable iff (!RST_N) // [RULE3]
		role_src && period_start && $stable(cfg.role) |=> TRIG_OUT)
		else $error("Source period start without trigger");

	a_slow_status: assert property (@(posedge REF_CLK) disable iff (!RST_N) // [RULE6]
		per_ok && role_sink && trig_known && too_slow |-> !restart ##1
		status == `TPSS_ST_SLOW)
		else $error("Slow sink did not report status 2");

	a_sink_status: assert property (@(posedge REF_CLK) disable iff (!RST_N) // [RULE8]
		per_ok && sink_sync |=> status == `TPSS_ST_SINK)
		else $error("Synchronised sink did not report status 6");

	a_src_status: assert property (@(posedge REF_CLK) disable iff (!RST_N) // [RULE8]
		per_ok && role_src && !link_src |=> status == `TPSS_ST_SRC)
		else $error("Source did not report status 5");

	a_link_status: assert property (@(posedge REF_CLK) disable iff (!RST_N) // [RULE9]
		per_ok && link_src && link_rise |-> ##2
		(status == `TPSS_ST_LINK || !$past(link_src && per_ok)))
		else $error("Link slave source did not report status 13");

	a_force_source: assert property (@(posedge REF_CLK) disable iff (!RST_N) // [RULE11]
		cfg.xmode == `TPSS_XM_SLAVE |-> cfg.role == `TPSS_ROLE_SRC)
		else $error("Link slave not forced to source role");

	a_read_clear: assert property (@(posedge REF_CLK) disable iff (!RST_N)
		rd_ist |=> (int_stat & ~$past(events)) == '0)
		else $error("Interrupt status not cleared by read");

	a_read_wait: assert property (@(posedge REF_CLK) disable iff (!RST_N)
		accept && !HWRITE |=> !HREADYOUT ##1 HREADYOUT)
		else $error("Read did not take exactly one wait state");

endmodule : tpss_top

// [hdl/tpss_defs.svh]
/*
 Constants of the task period sync scheduler: timing, register map, fields, codes.
 Assumes a 100 MHz clock and a 32-bit AHB-Lite register bus.
*/
`ifndef TPSS_DEFS_SVH
`define TPSS_DEFS_SVH

// ============================================================
// Timing
`define TPSS_CLK_PERIOD_NS 10
`define TPSS_TICK_US 250
`define TPSS_TICK_CYC ((`TPSS_TICK_US * 1000) / `TPSS_CLK_PERIOD_NS)
`define TPSS_SINCE_W 21
`define TPSS_SINCE_MAX 21'h1FFFFF

// ============================================================
// Register byte offsets
`define TPSS_OFS_CTRL 8'h00
`define TPSS_OFS_STATUS 8'h04
`define TPSS_OFS_INT_STAT 8'h08
`define TPSS_OFS_INT_MASK 8'h0C

// ============================================================
// Control fields
`define TPSS_PER_LSB 0
`define TPSS_PER_MSB 2
`define TPSS_ROLE_LSB 8
`define TPSS_ROLE_MSB 9
`define TPSS_XM_LSB 16
`define TPSS_XM_MSB 20
`define TPSS_PER_RST 3'h1
`define TPSS_ROLE_RST 2'h0
`define TPSS_XM_RST 5'h01

// ============================================================
// Codes
`define TPSS_PER_MIN 3'h1
`define TPSS_PER_MAX 3'h6
`define TPSS_ROLE_SRC 2'h1
`define TPSS_ROLE_SINK 2'h2
`define TPSS_XM_NONE 5'h01
`define TPSS_XM_MASTER 5'h19
`define TPSS_XM_SLAVE 5'h1A
`define TPSS_ST_NONE 8'h00
`define TPSS_ST_SLOW 8'h02
`define TPSS_ST_SRC 8'h05
`define TPSS_ST_SINK 8'h06
`define TPSS_ST_LINK 8'h0D
`define TPSS_TRIG_KNOWN 2'h2

// ============================================================
// Interrupt bits
`define TPSS_EV_W 4
`define TPSS_EV_TRIG_OUT 0
`define TPSS_EV_TRIG_IN 1
`define TPSS_EV_ACHIEVED 2
`define TPSS_EV_SLOW 3

`endif

// [hdl/tpss_pkg.sv]
/*
 Types of the task period sync scheduler.
 Assumes tpss_defs.svh on the include path.
*/
`include "tpss_defs.svh"

package tpss_pkg;

	// ============================================================
	// Task slot states
	typedef enum logic [1:0]
	{
		TS_IDLE = 2'h0,
		TS_FIRST = 2'h1,
		TS_ADV = 2'h3,
		TS_SECOND = 2'h2
	} tpss_slot_e;

	// ============================================================
	// Bus address phase and configuration
	typedef struct packed
	{
		logic valid;
		logic write;
		logic [7:0] addr;
	} tpss_acc_s;

	typedef struct packed
	{
		logic [4:0] xmode;
		logic [1:0] role;
		logic [2:0] period;
	} tpss_cfg_s;

	// Period code to number of 250 us ticks
	function automatic logic [5:0] tpss_period_ticks(input logic [2:0] code);
		logic [2:0] sh;
		sh = code - `TPSS_PER_MIN;
		if (code < `TPSS_PER_MIN || code > `TPSS_PER_MAX)
			tpss_period_ticks = 6'h00;
		else
			tpss_period_ticks = 6'h01 << sh;
	endfunction : tpss_period_ticks

endpackage : tpss_pkg

// [hdl/tpss_period_timer.sv]
/*
 Position period timer: a 250 us tick divider and a period counter.
 Assumes one clock; restart is a one-cycle pulse.
*/
`timescale 1ns/100ps
`include "tpss_defs.svh"

module tpss_period_timer
	import tpss_pkg::*;
#(
	parameter int TICK_CYCLES = `TPSS_TICK_CYC
)
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Control
	input wire logic run,
	input wire logic restart,
	input wire logic [5:0] period_ticks,
	// Period start pulse
	output logic period_start
);

	localparam int DW = $clog2(TICK_CYCLES + 1);

	logic [DW-1:0] div;
	logic [5:0] pcnt;
	wire div_last = (div == DW'(TICK_CYCLES - 1));
	wire per_last = (pcnt == period_ticks - 6'h01);
	wire [DW-1:0] next_div = div_last ? '0 : div + DW'(1);
	wire [5:0] next_pcnt = per_last ? 6'h00 : pcnt + 6'h01;

	// ============================================================
	// Counters
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			div <= '0;
			pcnt <= 6'h00;
		end
		else if (!run || restart)
		begin
			div <= '0;
			pcnt <= 6'h00;
		end
		else
		begin
			div <= next_div;
			if (div_last)
				pcnt <= next_pcnt;
		end
	end

	// Start of each own period, or at once on restart
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			period_start <= 1'b0;
		else
			period_start <= run && (restart || (div_last && per_last)); // [RULE3] [RULE16]
	end

endmodule : tpss_period_timer

// [hdl/tpss_task_seq.sv]
/*
 Task slot sequencer: first task, advanced motion task, second task.
 Assumes task_done pulses come from the task engines.
*/
`timescale 1ns/100ps

module tpss_task_seq
	import tpss_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Period start and slot completion
	input wire logic period_start,
	input wire logic [2:0] task_done,
	// Slot start pulses
	output logic [2:0] task_start
);

	tpss_slot_e state;
	tpss_slot_e next_state;
	logic [2:0] next_start;

	// ============================================================
	// Next state
	always_comb
	begin
		next_state = state;
		next_start = 3'h0;
		if (period_start)
		begin
			next_state = TS_FIRST; // [RULE15]
			next_start = 3'h1;
		end
		else
		begin
			unique case (state)
				TS_IDLE: next_state = TS_IDLE;
				TS_FIRST:
					if (task_done[0])
					begin
						next_state = TS_ADV; // [RULE14]
						next_start = 3'h2;
					end
				TS_ADV:
					if (task_done[1])
					begin
						next_state = TS_SECOND; // [RULE14]
						next_start = 3'h4;
					end
				TS_SECOND:
					if (task_done[2])
						next_state = TS_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state <= TS_IDLE;
			task_start <= 3'h0;
		end
		else
		begin
			state <= next_state;
			task_start <= next_start;
		end
	end

	// ============================================================
	// Checks
	sequence s_adv_done;
		(state == TS_ADV) && task_done[1] && !period_start;
	endsequence

	a_slot_order: assert property (@(posedge clk) disable iff (!rst_n) // [RULE14]
		s_adv_done |=> task_start == 3'h4 && state == TS_SECOND)
		else $error("Second task did not follow advanced motion task");

	a_slot_restart: assert property (@(posedge clk) disable iff (!rst_n) // [RULE15]
		period_start |=> task_start == 3'h1 && state == TS_FIRST)
		else $error("Period start did not restart the slot sequence");

endmodule : tpss_task_seq

// [dv/tpss_sibling.sv]
/*
 Sibling option modules: a trigger producer and the task engines.
 Assumes one clock; the bench enables the producer and sets its spacing.
*/
`timescale 1ns/100ps

module tpss_sibling
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Producer control
	input wire logic trig_en,
	input wire logic [15:0] trig_cycles,
	// Task engine handshake
	input wire logic [2:0] task_start,
	output logic [2:0] task_done,
	// Trigger line, held low when idle
	output logic trig
);
	// ============================================================
	// Trigger producer and task engines
	logic [15:0] cnt;
	logic [2:0] d1;
	logic [2:0] d2;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cnt <= 16'h0000;
			trig <= 1'b0;
			d1 <= 3'h0;
			d2 <= 3'h0;
			task_done <= 3'h0;
		end
		else
		begin
			cnt <= (!trig_en || cnt >= trig_cycles - 16'h0001) ? 16'h0000 : cnt + 16'h0001;
			trig <= trig_en && (cnt < 16'h0002);
			d1 <= task_start;
			d2 <= d1;
			task_done <= d2;
		end
	end
endmodule : tpss_sibling

// [dv/tpss_top_test.sv]
/*
 Self-checking bench of the task period sync scheduler.
 Assumes the sibling model in tpss_sibling.sv and TICK_CYCLES of 20.
*/
`timescale 1ns/100ps
`include "tpss_defs.svh"

module tpss_top_test;
	import tpss_pkg::*;

	// ============================================================
	// Signals
	logic REF_CLK;
	logic RST_N;
	logic HSEL;
	logic [31:0] HADDR;
	logic [1:0] HTRANS;
	logic HWRITE;
	logic [2:0] HSIZE;
	logic [31:0] HWDATA;
	logic [31:0] HRDATA;
	logic HREADYOUT;
	logic HRESP;
	logic TRIG_OUT;
	logic LINK_INT_IN;
	logic [2:0] TASK_DONE;
	logic [2:0] TASK_START;
	logic IRQ;
	logic trig;
	logic trig_q;
	logic trig_en;
	logic [15:0] trig_cycles;
	logic [31:0] rdat;
	logic [31:0] q;
	int errors = 0;
	int checks_done = 0;
	int cyc = 0;
	int to_n = 0;
	int to_last = 0;
	int to_prev = 0;
	int tr_n = 0;
	int tr_last = 0;
	int ts_last [3] = '{0, 0, 0};
	int d1;
	int s;
	int n0;

	tpss_top #(.TICK_CYCLES(20)) DUT (.REF_CLK(REF_CLK), .RST_N(RST_N), .HSEL(HSEL),
		.HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA),
		.HREADY(HREADYOUT), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
		.TRIG_IN(trig), .TRIG_OUT(TRIG_OUT), .LINK_INT_IN(LINK_INT_IN),
		.TASK_DONE(TASK_DONE), .TASK_START(TASK_START), .IRQ(IRQ));

	tpss_sibling SIB (.clk(REF_CLK), .rst_n(RST_N), .trig_en(trig_en),
		.trig_cycles(trig_cycles), .task_start(TASK_START), .task_done(TASK_DONE), .trig(trig));

	// ============================================================
	// Clock and event monitor
	initial
	begin
		REF_CLK = 1'b0;
		forever #5 REF_CLK = ~REF_CLK;
	end

	always @(posedge REF_CLK)
	begin
		cyc <= cyc + 1;
		trig_q <= trig;
		if (TRIG_OUT === 1'b1)
		begin
			to_prev <= to_last;
			to_last <= cyc;
			to_n <= to_n + 1;
		end
		if (TASK_START[0] === 1'b1)
			ts_last[0] <= cyc;
		if (TASK_START[1] === 1'b1)
			ts_last[1] <= cyc;
		if (TASK_START[2] === 1'b1)
			ts_last[2] <= cyc;
		if (trig === 1'b1 && trig_q === 1'b0)
		begin
			tr_last <= cyc;
			tr_n <= tr_n + 1;
		end
	end

	// ============================================================
	// Bus and checking tasks
	task check(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check

	task wait_ready;
		do @(posedge REF_CLK); while (HREADYOUT !== 1'b1);
		rdat = HRDATA;
		check(HRESP, 1'b0);
	endtask : wait_ready

	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge REF_CLK);
		HSEL <= 1'b1;
		HTRANS <= 2'h2;
		HWRITE <= w;
		HADDR <= {24'h000000, a};
		wait_ready;
		HTRANS <= 2'h0;
		HWDATA <= d;
		wait_ready;
		q = rdat;
	endtask : bus

	function automatic logic [31:0] ctrl(input logic [4:0] xm, input logic [1:0] r,
		input logic [2:0] c);
		ctrl = {11'h000, xm, 6'h00, r, 5'h00, c};
	endfunction : ctrl

	// ============================================================
	// Scenarios
	task t_reset;
		bus(0, `TPSS_OFS_CTRL, 32'h0);
		check(q, ctrl(`TPSS_XM_NONE, `TPSS_ROLE_RST, `TPSS_PER_RST));
		bus(0, `TPSS_OFS_STATUS, 32'h0);
		check(q, 32'h0);
		bus(1, 8'h10, 32'hFFFFFFFF);
		bus(0, 8'h10, 32'h0);
		check(q, 32'h0);
	endtask : t_reset

	task t_irq;
		bus(1, `TPSS_OFS_INT_MASK, 32'h4);
		bus(0, `TPSS_OFS_INT_STAT, 32'h0);
		check(IRQ, 1'b0);
		bus(1, `TPSS_OFS_CTRL, ctrl(`TPSS_XM_NONE, `TPSS_ROLE_SRC, 3'h1));
		repeat (4) @(posedge REF_CLK);
		check(IRQ, 1'b1);
		bus(0, `TPSS_OFS_INT_STAT, 32'h0);
		check(q[2], 1'b1);
		repeat (2) @(posedge REF_CLK);
		check(IRQ, 1'b0);
		bus(1, `TPSS_OFS_INT_MASK, 32'h0);
	endtask : t_irq

	task t_source;
		for (int c = 1; c <= 6; c++)
		begin
			bus(1, `TPSS_OFS_CTRL, ctrl(`TPSS_XM_MASTER, `TPSS_ROLE_SRC, c[2:0]));
			s = to_n;
			wait (to_n >= s + 3);
			repeat (12) @(posedge REF_CLK);
			check(to_last - to_prev, 20 << (c - 1));
			check(ts_last[0], to_last);
			check(ts_last[1] > ts_last[0] && ts_last[2] > ts_last[1], 1);
		end
		bus(1, `TPSS_OFS_STATUS, 32'hFF);
		bus(0, `TPSS_OFS_STATUS, 32'h0);
		check(q, `TPSS_ST_SRC);
		bus(1, `TPSS_OFS_CTRL, ctrl(`TPSS_XM_MASTER, `TPSS_ROLE_SRC, 3'h7));
		repeat (3) @(posedge REF_CLK);
		s = to_n;
		bus(0, `TPSS_OFS_STATUS, 32'h0);
		check(q, `TPSS_ST_NONE);
		repeat (200) @(posedge REF_CLK);
		check(to_n, s);
	endtask : t_source

	task t_sink;
		bus(1, `TPSS_OFS_CTRL, ctrl(`TPSS_XM_NONE, `TPSS_ROLE_SINK, 3'h1));
		trig_en <= 1'b1;
		s = tr_n;
		wait (tr_n >= s + 3);
		n0 = to_n;
		repeat (6) @(posedge REF_CLK);
		check(ts_last[0] - tr_last, 2);
		s = tr_n;
		wait (tr_n >= s + 1);
		repeat (6) @(posedge REF_CLK);
		check(ts_last[0] - tr_last, 2);
		bus(0, `TPSS_OFS_STATUS, 32'h0);
		check(q, `TPSS_ST_SINK);
		trig_cycles <= 16'd80;
		bus(1, `TPSS_OFS_CTRL, ctrl(`TPSS_XM_NONE, `TPSS_ROLE_SINK, 3'h3));
		s = tr_n;
		wait (tr_n >= s + 3);
		bus(0, `TPSS_OFS_STATUS, 32'h0);
		check(q, `TPSS_ST_SINK);
		bus(1, `TPSS_OFS_CTRL, ctrl(`TPSS_XM_NONE, `TPSS_ROLE_SINK, 3'h4));
		s = tr_n;
		wait (tr_n >= s + 3);
		bus(0, `TPSS_OFS_STATUS, 32'h0);
		check(q, `TPSS_ST_SLOW);
		bus(0, `TPSS_OFS_INT_STAT, 32'h0);
		check(q[3], 1'b1);
		check(to_n, n0);
		trig_en <= 1'b0;
	endtask : t_sink

	task t_link;
		bus(1, `TPSS_OFS_CTRL, ctrl(`TPSS_XM_SLAVE, `TPSS_ROLE_SINK, 3'h3));
		bus(0, `TPSS_OFS_CTRL, 32'h0);
		check(q, ctrl(`TPSS_XM_SLAVE, `TPSS_ROLE_SRC, 3'h3));
		bus(0, `TPSS_OFS_STATUS, 32'h0);
		check(q, `TPSS_ST_NONE);
		d1 = cyc;
		LINK_INT_IN <= 1'b1;
		repeat (2) @(posedge REF_CLK);
		LINK_INT_IN <= 1'b0;
		repeat (2) @(posedge REF_CLK);
		check(to_last, d1 + 3);
		check(ts_last[0], d1 + 3);
		bus(0, `TPSS_OFS_STATUS, 32'h0);
		check(q, `TPSS_ST_LINK);
	endtask : t_link

	// ============================================================
	// Verdict, watchdog and main sequence
	task end_sim;
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : end_sim

	initial
	begin
		repeat (20000) @(posedge REF_CLK);
		errors++;
		end_sim;
	end

	initial
	begin
		RST_N = 1'b0;
		HSEL = 1'b0;
		HADDR = 32'h0;
		HTRANS = 2'h0;
		HWRITE = 1'b0;
		HSIZE = 3'h2;
		HWDATA = 32'h0;
		LINK_INT_IN = 1'b0;
		trig_en = 1'b0;
		trig_cycles = 16'd90;
		repeat (16) @(posedge REF_CLK);
		RST_N <= 1'b1;
		t_reset;
		t_irq;
		t_source;
		t_sink;
		t_link;
		end_sim;
	end
endmodule : tpss_top_test
